//--- rtl/serial_pkg.sv
// Constants, types and helpers shared by the dual asynchronous serial channel block
// Summary of operation
// - Two independent channels convert received serial to parallel and CPU data to serial.
// - Character length of five to eight data bits, chosen per channel.
// - Even, odd or no parity; generated on transmit, checked on receive.
// - Transmitter appends one, one and a half, or two stop bits.
// - Transmit and receive characters are held in sixteen-byte FIFOs.
// - Transmit, receive, line-status and modem-status interrupts, each enabled separately.
// - Reference clock up to 16 MHz, serial rates up to 1 Mbaud.
// - Baud generator divides the reference clock by any divisor from 1 to 65535.
// - One external reference clock feeds the divisors of both channels.
// - All transfer and error status readable at any time without disturbing transfers.
// - Three address lines pick the internal register of each access.
// - Each channel acts on strobes only while its own select is asserted.
// - Bus driver direction output is high while any port is being read.
// - Modem status bit 4 shows the clear-to-send line state.
// - Modem status bit 0 flags a clear-to-send change since the last read.
// - Data bit 0 is the least significant and the first bit on the line.
// - Bits 7 and 5 show carrier and data-set-ready; bits 3 and 1 flag changes.
// - Terminal-ready output is low while modem control bit 0 is set, high after reset.
// - Interrupt output is enabled only by modem control bit 3; high while any enabled source.
package serial_pkg;
	localparam int NUM_CH     = 2;
	localparam int FIFO_DEPTH = 16;
	localparam int PTR_W      = 4;
	localparam int CNT_W      = 5;
	localparam int DIV_W      = 16;
	localparam int TICK_W     = 6;
	localparam int TO_W       = 10;
	localparam int PIN_W      = 9;
	localparam int MC_W       = 5;

	// Synchronised pin vector: serial in, cts_n, dsr_n, dcd_n (two each), then reference clock
	localparam int PIN_SIN = 0;
	localparam int PIN_CTS = 2;
	localparam int PIN_DSR = 4;
	localparam int PIN_DCD = 6;
	localparam int PIN_REF = 8;
	localparam logic [PIN_W-1:0] PIN_RESET = 9'h0FF;

	localparam logic [2:0] REG_DATA       = 3'h0;
	localparam logic [2:0] REG_INT_EN     = 3'h1;
	localparam logic [2:0] REG_INT_ID     = 3'h2;
	localparam logic [2:0] REG_LINE_CTRL  = 3'h3;
	localparam logic [2:0] REG_MODEM_CTRL = 3'h4;
	localparam logic [2:0] REG_LINE_STAT  = 3'h5;
	localparam logic [2:0] REG_MODEM_STAT = 3'h6;
	localparam logic [2:0] REG_SCRATCH    = 3'h7;

	localparam int IE_RX = 0;
	localparam int IE_TX = 1;
	localparam int IE_LS = 2;
	localparam int IE_MS = 3;
	localparam int FC_ENABLE = 0;
	localparam int FC_RX_CLR = 1;
	localparam int FC_TX_CLR = 2;
	localparam int FC_TRIG   = 6;
	localparam int TERMINAL_READY_CTRL_BIT = 0;
	localparam int MC_RTS     = 1;
	localparam int MC_IRQ_EN  = 3;
	localparam int CTS_CHANGED_BIT           = 0;
	localparam int DATASET_READY_CHANGED_BIT = 1;
	localparam int CARRIER_CHANGED_BIT       = 3;
	localparam int CTS_STATE_BIT             = 4;
	localparam int DATASET_READY_STATE_BIT   = 5;
	localparam int CARRIER_STATE_BIT         = 7;

	localparam logic [3:0] ID_NONE    = 4'h1;
	localparam logic [3:0] ID_LINE    = 4'h6;
	localparam logic [3:0] ID_RXDATA  = 4'h4;
	localparam logic [3:0] ID_TIMEOUT = 4'hC;
	localparam logic [3:0] ID_TXEMPTY = 4'h2;
	localparam logic [3:0] ID_MODEM   = 4'h0;

	localparam logic [CNT_W-1:0] TRIG_1  = 5'h01;
	localparam logic [CNT_W-1:0] TRIG_4  = 5'h04;
	localparam logic [CNT_W-1:0] TRIG_8  = 5'h08;
	localparam logic [CNT_W-1:0] TRIG_14 = 5'h0E;

	// Sixteen ticks per bit; receiver start bit is checked at mid bit
	localparam logic [TICK_W-1:0] BIT_LAST       = 6'h0F;
	localparam logic [TICK_W-1:0] SAMPLE_MID     = 6'h07;
	localparam logic [TICK_W-1:0] STOP_HALF_LAST = 6'h17;
	localparam logic [TICK_W-1:0] STOP_TWO_LAST  = 6'h1F;
	localparam logic [TICK_W-1:0] TICK_ONE       = 6'h01;
	// Four ten-bit character times of ticks
	localparam logic [TO_W-1:0]   RX_TIMEOUT     = 10'h280;
	localparam logic [2:0]        WORD_MIN_LAST  = 3'h4;
	localparam logic [1:0]        LEN_MAX        = 2'h3;
	localparam logic [7:0]        MASK_ALL       = 8'hFF;

	typedef struct packed {
		logic       dlab;
		logic       brk;
		logic       stick;
		logic       even;
		logic       par_en;
		logic       stop2;
		logic [1:0] len;
	} line_ctrl_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;

	typedef struct packed {
		logic       brk;
		logic       frame;
		logic       parity;
		logic [7:0] data;
	} rx_entry_t;

	typedef enum logic [4:0] {
		TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
		TX_PAR  = 5'b01000, TX_STOP  = 5'b10000
	} tx_state_t;

	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
		RX_PAR  = 5'b01000, RX_STOP  = 5'b10000
	} rx_state_t;

	localparam line_ctrl_t LINE_CTRL_RESET = 8'h00;

	// Parity bit that goes with data d under line setting l
	function automatic logic par_bit(input line_ctrl_t l, input logic [7:0] d);
		par_bit = l.stick ? ~l.even : (l.even ? ^d : ~^d);
	endfunction
endpackage

//--- rtl/char_fifo.sv
// Sixteen-entry character FIFO with a registered head output
`timescale 1ns/1ps
module char_fifo
	import serial_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             mclk_i,
	input  wire logic             rst_i,
	input  wire logic             clr_i,
	input  wire logic             push_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	input  wire logic             pop_i,
	output logic      [WIDTH-1:0] head_o,
	output logic      [CNT_W-1:0] count_o,
	output logic                  full_o,
	output logic                  empty_o
);
	logic [WIDTH-1:0] mem_q [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [WIDTH-1:0] head_q, head_d;
	logic             do_push, do_pop;

	assign full_o  = cnt_q == CNT_W'(FIFO_DEPTH);
	assign empty_o = cnt_q == '0;
	assign count_o = cnt_q;
	assign head_o  = head_q;

	always_comb begin
		do_push = push_i && !full_o && !clr_i;
		do_pop  = pop_i && !empty_o && !clr_i;
		wr_d    = wr_q + PTR_W'(do_push);
		rd_d    = rd_q + PTR_W'(do_pop);
		cnt_d   = cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
		if (clr_i) begin
			wr_d  = '0;
			rd_d  = '0;
			cnt_d = '0;
		end
		// Bypass so a character written into an empty slot is visible next cycle
		head_d = (do_push && wr_q == rd_d) ? wdata_i : mem_q[rd_d];
	end

	always_ff @(posedge mclk_i) begin
		if (do_push) begin
			mem_q[wr_q] <= wdata_i;
		end
		head_q <= head_d;
		if (rst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end
endmodule

//--- rtl/baud_tick.sv
// Programmable baud divisor producing one tick per sixteenth of a bit
`timescale 1ns/1ps
module baud_tick
	import serial_pkg::*;
(
	input  wire logic             mclk_i,
	input  wire logic             rst_i,
	input  wire logic             ref_edge_i,
	input  wire logic             load_i,
	input  wire logic [DIV_W-1:0] divisor_i,
	output logic                  tick_o
);
	logic [DIV_W-1:0] cnt_q, cnt_d;
	logic             tick_q, tick_d;

	assign tick_o = tick_q;

	always_comb begin
		cnt_d  = cnt_q;
		tick_d = 1'b0;
		if (load_i) begin
			cnt_d = '0;
		end else if (ref_edge_i && divisor_i != '0) begin
			if (cnt_q >= divisor_i - DIV_W'(1)) begin
				cnt_d  = '0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + DIV_W'(1);
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end
endmodule

//--- rtl/dual_async_serial_channels.sv
// Two asynchronous serial channels sharing one CPU register port and reference clock
`timescale 1ns/1ps
module dual_async_serial_channels
	import serial_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	input  wire logic [2:0]        reg_select_line_i,
	input  wire logic              select_serial_first_i,
	input  wire logic              select_serial_second_i,
	input  wire logic              select_printer_port_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	input  wire logic [7:0]        wdata_i,
	output logic      [7:0]        rdata_o,
	output logic                   bus_driver_dir_out_o,
	input  wire logic              ref_clk_i,
	input  wire logic [NUM_CH-1:0] serial_in_i,
	output logic      [NUM_CH-1:0] serial_out_o,
	input  wire logic [NUM_CH-1:0] cts_n_i,
	input  wire logic [NUM_CH-1:0] dsr_n_i,
	input  wire logic [NUM_CH-1:0] dcd_n_i,
	output logic      [NUM_CH-1:0] dtr_n_o,
	output logic      [NUM_CH-1:0] rts_n_o,
	output logic                   serial_irq_first_o,
	output logic                   serial_irq_first_oe_o,
	output logic                   serial_irq_second_o,
	output logic                   serial_irq_second_oe_o
);
	bus_req_t          req;
	logic [NUM_CH-1:0] sel, irq, irq_oe;
	logic [7:0]        ch_rd [NUM_CH];
	logic [PIN_W-1:0]  pin_meta_q, pin_sync_q;
	logic              ref_last_q, ref_edge;
	logic [7:0]        rdata_q, rdata_d;

	assign req = '{addr: reg_select_line_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
	assign sel = {select_serial_second_i, select_serial_first_i};
	assign bus_driver_dir_out_o = rd_i && (|sel || select_printer_port_i);
	assign rdata_o = rdata_q;
	assign serial_irq_first_o     = irq[0];
	assign serial_irq_first_oe_o  = irq_oe[0];
	assign serial_irq_second_o    = irq[1];
	assign serial_irq_second_oe_o = irq_oe[1];
	// One reference clock edge drives both channel divisors
	assign ref_edge = pin_sync_q[PIN_REF] && !ref_last_q;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pin_meta_q <= PIN_RESET;
			pin_sync_q <= PIN_RESET;
			ref_last_q <= 1'b0;
		end else begin
			pin_meta_q <= {ref_clk_i, dcd_n_i, dsr_n_i, cts_n_i, serial_in_i};
			pin_sync_q <= pin_meta_q;
			ref_last_q <= pin_sync_q[PIN_REF];
		end
	end

	// The printer port select only drives the bus direction; it reads as zero
	always_comb begin
		rdata_d = '0;
		if (rd_i && sel[0]) begin
			rdata_d = ch_rd[0];
		end else if (rd_i && sel[1]) begin
			rdata_d = ch_rd[1];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	for (genvar c = 0; c < NUM_CH; c++) begin : ch
		logic             wr_c, rd_c, rx_in, tick;
		logic [2:0]       lines, lines_last_q;
		logic [DIV_W-1:0] div_q, div_d;
		logic [3:0]       ier_q, ier_d, delta_q, delta_d, int_id;
		line_ctrl_t       lcr_q, lcr_d;
		logic [MC_W-1:0]  mcr_q, mcr_d;
		logic [7:0]       scr_q, scr_d, lsr, modem_status_reg, len_mask;
		logic [1:0]       trig_q, trig_d;
		logic             fen_q, fen_d, oe_q, oe_d, thre_q, thre_d, irq_q;
		logic             tx_empty_last_q, div_load, rx_clr, tx_clr, msr_read;
		logic [CNT_W-1:0] trig_lvl, rx_count;
		logic [TO_W-1:0]  to_q, to_d;
		logic [2:0]       word_last;
		logic             tx_push, tx_pop, tx_full, tx_empty;
		logic             rx_push, rx_pop, rx_full, rx_empty;
		logic [7:0]       tx_head;
		rx_entry_t        rx_head, rx_entry;

		tx_state_t         tx_st_q, tx_st_d;
		rx_state_t         rx_st_q, rx_st_d;
		logic [7:0]        tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
		logic [2:0]        tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d;
		logic [TICK_W-1:0] tx_tk_q, tx_tk_d, rx_tk_q, rx_tk_d, stop_last;
		logic              tx_par_q, tx_par_d, tx_out_q, tx_out_d, tx_done;
		logic              rx_pb_q, rx_pb_d, rx_done;

		assign wr_c      = req.wr && sel[c];
		assign rd_c      = req.rd && sel[c];
		assign rx_in     = pin_sync_q[PIN_SIN+c];
		assign lines     = ~{pin_sync_q[PIN_DCD+c], pin_sync_q[PIN_DSR+c], pin_sync_q[PIN_CTS+c]};
		assign word_last = WORD_MIN_LAST + {1'b0, lcr_q.len};
		assign len_mask  = MASK_ALL >> (LEN_MAX - lcr_q.len);
		assign msr_read  = rd_c && req.addr == REG_MODEM_STAT;

		baud_tick u_baud (
			.mclk_i    (mclk_i),
			.rst_i     (rst_i),
			.ref_edge_i(ref_edge),
			.load_i    (div_load),
			.divisor_i (div_q),
			.tick_o    (tick)
		);

		char_fifo #(.WIDTH(8)) u_tx_fifo (
			.mclk_i (mclk_i),
			.rst_i  (rst_i),
			.clr_i  (tx_clr),
			.push_i (tx_push),
			.wdata_i(req.wdata),
			.pop_i  (tx_pop),
			.head_o (tx_head),
			.count_o(),
			.full_o (tx_full),
			.empty_o(tx_empty)
		);

		char_fifo #(.WIDTH($bits(rx_entry_t))) u_rx_fifo (
			.mclk_i (mclk_i),
			.rst_i  (rst_i),
			.clr_i  (rx_clr),
			.push_i (rx_push),
			.wdata_i(rx_entry),
			.pop_i  (rx_pop),
			.head_o (rx_head),
			.count_o(rx_count),
			.full_o (rx_full),
			.empty_o(rx_empty)
		);

		always_comb begin
			case (trig_q)
				2'h0: trig_lvl = TRIG_1;
				2'h1: trig_lvl = TRIG_4;
				2'h2: trig_lvl = TRIG_8;
				default: trig_lvl = TRIG_14;
			endcase
			if (!fen_q) begin
				trig_lvl = TRIG_1;
			end
			// Fixed priority: line status, receive data, timeout, transmit empty, modem
			if (ier_q[IE_LS] && (oe_q || (!rx_empty && |rx_head[10:8]))) begin
				int_id = ID_LINE;
			end else if (ier_q[IE_RX] && !rx_empty && rx_count >= trig_lvl) begin
				int_id = ID_RXDATA;
			end else if (ier_q[IE_RX] && fen_q && !rx_empty && to_q == RX_TIMEOUT) begin
				int_id = ID_TIMEOUT;
			end else if (ier_q[IE_TX] && thre_q) begin
				int_id = ID_TXEMPTY;
			end else if (ier_q[IE_MS] && |delta_q) begin
				int_id = ID_MODEM;
			end else begin
				int_id = ID_NONE;
			end
			lsr = {fen_q && !rx_empty && |rx_head[10:8], tx_empty && tx_st_q == TX_IDLE,
				tx_empty, !rx_empty && rx_head.brk, !rx_empty && rx_head.frame,
				!rx_empty && rx_head.parity, oe_q, !rx_empty};
			modem_status_reg = '0;
			modem_status_reg[CTS_STATE_BIT]             = lines[0];
			modem_status_reg[DATASET_READY_STATE_BIT]   = lines[1];
			modem_status_reg[CARRIER_STATE_BIT]         = lines[2];
			modem_status_reg[CTS_CHANGED_BIT]           = delta_q[CTS_CHANGED_BIT];
			modem_status_reg[DATASET_READY_CHANGED_BIT] = delta_q[DATASET_READY_CHANGED_BIT];
			modem_status_reg[CARRIER_CHANGED_BIT]       = delta_q[CARRIER_CHANGED_BIT];
			// Status reads only clear their own flags and never stall the channel
			case (req.addr)
				REG_DATA: ch_rd[c] = lcr_q.dlab ? div_q[7:0] : rx_head.data;
				REG_INT_EN: ch_rd[c] = lcr_q.dlab ? div_q[15:8] : {4'h0, ier_q};
				REG_INT_ID: ch_rd[c] = {fen_q, fen_q, 2'h0, int_id};
				REG_LINE_CTRL: ch_rd[c] = lcr_q;
				REG_MODEM_CTRL: ch_rd[c] = {3'h0, mcr_q};
				REG_LINE_STAT: ch_rd[c] = lsr;
				REG_MODEM_STAT: ch_rd[c] = modem_status_reg;
				default: ch_rd[c] = scr_q;
			endcase
		end

		always_comb begin
			div_d = div_q;
			ier_d = ier_q;
			lcr_d = lcr_q;
			mcr_d = mcr_q;
			scr_d = scr_q;
			fen_d = fen_q;
			trig_d = trig_q;
			div_load = 1'b0;
			rx_clr = 1'b0;
			tx_clr = 1'b0;
			tx_push = 1'b0;
			if (wr_c) begin
				case (req.addr)
					REG_DATA: begin
						if (lcr_q.dlab) begin
							div_d[7:0] = req.wdata;
							div_load = 1'b1;
						end else begin
							tx_push = 1'b1;
						end
					end
					REG_INT_EN: begin
						if (lcr_q.dlab) begin
							div_d[15:8] = req.wdata;
							div_load = 1'b1;
						end else begin
							ier_d = req.wdata[3:0];
						end
					end
					REG_INT_ID: begin
						fen_d = req.wdata[FC_ENABLE];
						rx_clr = req.wdata[FC_RX_CLR] || (req.wdata[FC_ENABLE] != fen_q);
						tx_clr = req.wdata[FC_TX_CLR] || (req.wdata[FC_ENABLE] != fen_q);
						trig_d = req.wdata[FC_TRIG+:2];
					end
					REG_LINE_CTRL: lcr_d = req.wdata;
					REG_MODEM_CTRL: mcr_d = req.wdata[MC_W-1:0];
					REG_SCRATCH: scr_d = req.wdata;
					default: scr_d = scr_q;
				endcase
			end
			rx_pop = rd_c && req.addr == REG_DATA && !lcr_q.dlab;
			// A new event in the clearing cycle keeps its flag set
			oe_d = (rx_push && rx_full) || (oe_q && !(rd_c && req.addr == REG_LINE_STAT));
			delta_d = {lines[2], 1'b0, lines[1:0]} ^ {lines_last_q[2], 1'b0, lines_last_q[1:0]};
			delta_d = delta_d | (delta_q & {4{!msr_read}});
			thre_d = (tx_empty && !tx_empty_last_q) ||
				(wr_c && req.addr == REG_INT_EN && !lcr_q.dlab && tx_empty &&
				req.wdata[IE_TX] && !ier_q[IE_TX]) ||
				(thre_q && !tx_push && !(rd_c && req.addr == REG_INT_ID && int_id == ID_TXEMPTY));
			to_d = to_q;
			if (rx_push || rx_pop || rx_empty) begin
				to_d = '0;
			end else if (tick && to_q != RX_TIMEOUT) begin
				to_d = to_q + TO_W'(1);
			end
		end

		always_ff @(posedge mclk_i) begin
			if (rst_i) begin
				div_q <= '0;
				ier_q <= '0;
				lcr_q <= LINE_CTRL_RESET;
				mcr_q <= '0;
				scr_q <= '0;
				fen_q <= 1'b0;
				trig_q <= '0;
				oe_q <= 1'b0;
				delta_q <= '0;
				thre_q <= 1'b0;
				to_q <= '0;
				lines_last_q <= '0;
				tx_empty_last_q <= 1'b1;
				irq_q <= 1'b0;
			end else begin
				div_q <= div_d;
				ier_q <= ier_d;
				lcr_q <= lcr_d;
				mcr_q <= mcr_d;
				scr_q <= scr_d;
				fen_q <= fen_d;
				trig_q <= trig_d;
				oe_q <= oe_d;
				delta_q <= delta_d;
				thre_q <= thre_d;
				to_q <= to_d;
				lines_last_q <= lines;
				tx_empty_last_q <= tx_empty;
				irq_q <= int_id != ID_NONE;
			end
		end

		assign irq[c]          = irq_q;
		assign irq_oe[c]       = mcr_q[MC_IRQ_EN];
		assign dtr_n_o[c]      = ~mcr_q[TERMINAL_READY_CTRL_BIT];
		assign rts_n_o[c]      = ~mcr_q[MC_RTS];
		assign serial_out_o[c] = tx_out_q;

		always_comb begin
			tx_st_d = tx_st_q;
			tx_sh_d = tx_sh_q;
			tx_bit_d = tx_bit_q;
			tx_par_d = tx_par_q;
			tx_pop = 1'b0;
			tx_out_d = 1'b1;
			stop_last = lcr_q.stop2 ? (lcr_q.len == '0 ? STOP_HALF_LAST : STOP_TWO_LAST)
				: BIT_LAST;
			tx_done = tick && tx_tk_q == (tx_st_q == TX_STOP ? stop_last : BIT_LAST);
			tx_tk_d = tx_done ? '0 : tx_tk_q + (tick ? TICK_ONE : '0);
			case (tx_st_q)
				TX_IDLE: begin
					tx_tk_d = '0;
					if (!tx_empty) begin
						tx_pop = 1'b1;
						tx_sh_d = tx_head & len_mask;
						tx_par_d = par_bit(lcr_q, tx_head & len_mask);
						tx_bit_d = '0;
						tx_st_d = TX_START;
					end
				end
				TX_START: begin
					tx_out_d = 1'b0;
					if (tx_done) begin
						tx_st_d = TX_DATA;
					end
				end
				TX_DATA: begin
					tx_out_d = tx_sh_q[0];
					if (tx_done) begin
						tx_sh_d = tx_sh_q >> 1;
						tx_bit_d = tx_bit_q + 3'h1;
						if (tx_bit_q == word_last) begin
							tx_st_d = lcr_q.par_en ? TX_PAR : TX_STOP;
						end
					end
				end
				TX_PAR: begin
					tx_out_d = tx_par_q;
					if (tx_done) begin
						tx_st_d = TX_STOP;
					end
				end
				TX_STOP: begin
					if (tx_done) begin
						tx_st_d = TX_IDLE;
					end
				end
				default: tx_st_d = TX_IDLE;
			endcase
			if (lcr_q.brk) begin
				tx_out_d = 1'b0;
			end
		end

		always_comb begin
			rx_st_d = rx_st_q;
			rx_sh_d = rx_sh_q;
			rx_bit_d = rx_bit_q;
			rx_pb_d = rx_pb_q;
			rx_push = 1'b0;
			rx_done = tick && rx_tk_q == (rx_st_q == RX_START ? SAMPLE_MID : BIT_LAST);
			rx_tk_d = rx_done ? '0 : rx_tk_q + (tick ? TICK_ONE : '0);
			rx_entry.data = rx_sh_q;
			rx_entry.frame = !rx_in;
			rx_entry.parity = lcr_q.par_en && rx_pb_q != par_bit(lcr_q, rx_sh_q);
			rx_entry.brk = !rx_in && rx_sh_q == '0 && !rx_pb_q;
			case (rx_st_q)
				RX_IDLE: begin
					rx_tk_d = '0;
					rx_sh_d = '0;
					rx_pb_d = 1'b0;
					rx_bit_d = '0;
					if (!rx_in) begin
						rx_st_d = RX_START;
					end
				end
				RX_START: begin
					if (rx_done) begin
						rx_st_d = rx_in ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_done) begin
						rx_sh_d[rx_bit_q] = rx_in;
						rx_bit_d = rx_bit_q + 3'h1;
						if (rx_bit_q == word_last) begin
							rx_st_d = lcr_q.par_en ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (rx_done) begin
						rx_pb_d = rx_in;
						rx_st_d = RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_done) begin
						rx_push = 1'b1;
						rx_st_d = RX_IDLE;
					end
				end
				default: rx_st_d = RX_IDLE;
			endcase
		end

		always_ff @(posedge mclk_i) begin
			if (rst_i) begin
				tx_st_q <= TX_IDLE;
				tx_sh_q <= '0;
				tx_bit_q <= '0;
				tx_tk_q <= '0;
				tx_par_q <= 1'b0;
				tx_out_q <= 1'b1;
				rx_st_q <= RX_IDLE;
				rx_sh_q <= '0;
				rx_bit_q <= '0;
				rx_tk_q <= '0;
				rx_pb_q <= 1'b0;
			end else begin
				tx_st_q <= tx_st_d;
				tx_sh_q <= tx_sh_d;
				tx_bit_q <= tx_bit_d;
				tx_tk_q <= tx_tk_d;
				tx_par_q <= tx_par_d;
				tx_out_q <= tx_out_d;
				rx_st_q <= rx_st_d;
				rx_sh_q <= rx_sh_d;
				rx_bit_q <= rx_bit_d;
				rx_tk_q <= rx_tk_d;
				rx_pb_q <= rx_pb_d;
			end
		end
	end
endmodule

//--- tb/far_peer.sv
// Serial peer that echoes each transmit line and drives channel 0 modem lines
`timescale 1ns/1ps
module far_peer #(
	parameter int BIT_CYC = 256
) (
	input  wire logic       mclk_i,
	input  wire logic [1:0] serial_out_i,
	input  wire logic [2:0] lines_n_i,
	output logic      [1:0] serial_in_o,
	output logic      [1:0] cts_n_o,
	output logic      [1:0] dsr_n_o,
	output logic      [1:0] dcd_n_o,
	output logic      [7:0] cap_o
);
	assign serial_in_o = serial_out_i;
	assign cts_n_o = {1'b1, lines_n_i[0]};
	assign dsr_n_o = {1'b1, lines_n_i[1]};
	assign dcd_n_o = {1'b1, lines_n_i[2]};
	// Captures the first channel 1 frame at mid bit, first bit into bit 0
	initial begin
		cap_o = 8'h00;
		@(negedge serial_out_i[1]);
		repeat (BIT_CYC / 2) @(posedge mclk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge mclk_i);
			cap_o[i] = serial_out_i[1];
		end
	end
endmodule

//--- tb/dual_serial_chk.sv
// Port checker for the dual serial channel block
`timescale 1ns/1ps
module dual_serial_chk
	import serial_pkg::*;
(
	input wire logic       mclk_i,
	input wire logic       rst_i,
	input wire logic [2:0] reg_select_line_i,
	input wire logic       select_serial_first_i,
	input wire logic       select_serial_second_i,
	input wire logic       select_printer_port_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic       bus_driver_dir_out_o,
	input wire logic [1:0] serial_out_o,
	input wire logic [1:0] cts_n_i,
	input wire logic [1:0] dsr_n_i,
	input wire logic [1:0] dcd_n_i,
	input wire logic [1:0] dtr_n_o,
	input wire logic       serial_irq_first_oe_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	wire logic any_sel = select_serial_first_i | select_serial_second_i | select_printer_port_i;
	sequence ms_rd;
		rd_i && select_serial_first_i && !select_serial_second_i
			&& reg_select_line_i == REG_MODEM_STAT;
	endsequence
	sequence quiet;
		$stable({cts_n_i, dsr_n_i, dcd_n_i})[*5];
	endsequence
	sequence mc_wr;
		wr_i && select_serial_first_i && reg_select_line_i == REG_MODEM_CTRL;
	endsequence
	bus_dir_a: assert property (bus_driver_dir_out_o == (rd_i && any_sel))
		else $error("direction output wrong");
	rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data without read");
	dtr_follow_a: assert property (mc_wr |=> dtr_n_o[0] == !$past(wdata_i[0]))
		else $error("terminal ready wrong");
	irq_enable_a: assert property (mc_wr |=>
		serial_irq_first_oe_o == $past(wdata_i[3])) else $error("interrupt enable wrong");
	reset_idle_a: assert property ($fell(rst_i) |-> dtr_n_o == 2'h3 &&
		!serial_irq_first_oe_o && serial_out_o == 2'h3) else $error("reset state wrong");
	no_select_a: assert property (wr_i && !any_sel |=> $stable(dtr_n_o))
		else $error("write without select acted");
	printer_read_a: assert property (rd_i && select_printer_port_i
		&& !select_serial_first_i && !select_serial_second_i |=> rdata_o == 8'h00)
		else $error("printer read not zero");
	line_state_a: assert property (quiet ##0 ms_rd |=> rdata_o[7:4] ==
		{!$past(dcd_n_i[0]), 1'b0, !$past(dsr_n_i[0]), !$past(cts_n_i[0])})
		else $error("modem state wrong");
	delta_clear_a: assert property (quiet ##0 ms_rd ##1 ms_rd |=> rdata_o[3:0] == 4'h0)
		else $error("change flags not cleared");
endmodule
bind dual_async_serial_channels dual_serial_chk dual_serial_chk_i (.mclk_i, .rst_i,
	.reg_select_line_i, .select_serial_first_i, .select_serial_second_i, .select_printer_port_i,
	.wr_i, .rd_i, .wdata_i, .rdata_o, .bus_driver_dir_out_o, .serial_out_o, .cts_n_i, .dsr_n_i,
	.dcd_n_i, .dtr_n_o, .serial_irq_first_oe_o);

//--- tb/testbench.sv
// Self-checking bench for the dual serial channel block
`timescale 1ns/1ps
module testbench;
	import serial_pkg::*;
	logic       mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, ref_clk_i = 0;
	logic       select_serial_first_i = 0, select_serial_second_i = 0, select_printer_port_i = 0;
	logic [2:0] reg_select_line_i = 3'h0, lines_n = 3'h7;
	logic [7:0] wdata_i = 8'h00, rdata_o, cap;
	logic       bus_driver_dir_out_o, serial_irq_first_o, serial_irq_second_o;
	logic       serial_irq_first_oe_o, serial_irq_second_oe_o;
	logic [1:0] serial_in_i, serial_out_o, cts_n_i, dsr_n_i, dcd_n_i, dtr_n_o, rts_n_o;
	int         n_mismatch = 0, comparisons = 0;
	initial forever #2 mclk_i = ~mclk_i;
	initial forever #32 ref_clk_i = ~ref_clk_i;
	dual_async_serial_channels dual_async_serial_channels_i (.mclk_i, .rst_i, .reg_select_line_i,
		.select_serial_first_i, .select_serial_second_i, .select_printer_port_i, .wr_i, .rd_i,
		.wdata_i, .rdata_o, .bus_driver_dir_out_o, .ref_clk_i, .serial_in_i, .serial_out_o,
		.cts_n_i, .dsr_n_i, .dcd_n_i, .dtr_n_o, .rts_n_o, .serial_irq_first_o,
		.serial_irq_first_oe_o, .serial_irq_second_o, .serial_irq_second_oe_o);
	far_peer far_peer_i (.mclk_i, .serial_out_i(serial_out_o), .lines_n_i(lines_n),
		.serial_in_o(serial_in_i), .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i), .dcd_n_o(dcd_n_i),
		.cap_o(cap));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [2:0] s, input logic [2:0] a,
		input logic [7:0] v);
		@(posedge mclk_i);
		{select_printer_port_i, select_serial_second_i, select_serial_first_i} <= s;
		reg_select_line_i <= a;
		wdata_i <= v;
		wr_i <= w;
		rd_i <= !w;
		@(posedge mclk_i);
		{wr_i, rd_i, select_printer_port_i, select_serial_second_i, select_serial_first_i} <= 5'h00;
		#1;
	endtask
	task automatic rdchk(input logic [2:0] s, input logic [2:0] a, input logic [7:0] exp);
		bus(1'b0, s, a, 8'h00);
		chk(rdata_o, exp);
	endtask
	task automatic rd2chk(input logic [2:0] a, input logic [7:0] e0, input logic [7:0] e1);
		@(posedge mclk_i);
		{select_serial_first_i, rd_i, reg_select_line_i} <= {2'h3, a};
		@(posedge mclk_i);
		#1 chk(rdata_o, e0);
		@(posedge mclk_i);
		{select_serial_first_i, rd_i} <= 2'h0;
		#1 chk(rdata_o, e1);
	endtask
	task automatic t_reset;
		@(posedge mclk_i);
		#1;
		chk({2'h0, serial_irq_second_oe_o, serial_irq_first_oe_o, dtr_n_o, serial_out_o},
			8'h0F);
		$display("reset test done");
	endtask
	task automatic t_modem;
		bus(1'b1, 3'h1, REG_MODEM_CTRL, 8'h09);
		bus(1'b1, 3'h0, REG_MODEM_CTRL, 8'h01);
		chk({2'h0, rts_n_o, dtr_n_o, serial_irq_second_oe_o, serial_irq_first_oe_o},
			8'h39);
		rdchk(3'h1, REG_MODEM_CTRL, 8'h09);
		rdchk(3'h4, REG_MODEM_CTRL, 8'h00);
		bus(1'b1, 3'h1, REG_INT_EN, 8'h02);
		rdchk(3'h1, REG_INT_ID, 8'h02);
		chk({6'h0, serial_irq_second_o, serial_irq_first_o}, 8'h01);
		$display("modem control test done");
	endtask
	task automatic t_msr;
		@(posedge mclk_i) lines_n <= 3'h0;
		repeat (8) @(posedge mclk_i);
		rd2chk(REG_MODEM_STAT, 8'hBB, 8'hB0);
		rdchk(3'h2, REG_MODEM_STAT, 8'h00);
		@(posedge mclk_i) lines_n <= 3'h7;
		repeat (8) @(posedge mclk_i);
		rdchk(3'h1, REG_MODEM_STAT, 8'h0B);
		$display("modem status test done");
	endtask
	task automatic t_loop;
		for (int c = 1; c < 3; c++) begin
			bus(1'b1, c[2:0], REG_LINE_CTRL, 8'h80);
			bus(1'b1, c[2:0], REG_DATA, 8'h01);
			bus(1'b1, c[2:0], REG_LINE_CTRL, c == 1 ? 8'h04 : 8'h1B);
		end
		bus(1'b1, 3'h2, REG_INT_ID, 8'h01);
		bus(1'b1, 3'h1, REG_DATA, 8'hF5);
		bus(1'b1, 3'h2, REG_DATA, 8'hA5);
		bus(1'b1, 3'h2, REG_DATA, 8'h3C);
		repeat (6500) @(posedge mclk_i);
		chk(cap, 8'hA5);
		rdchk(3'h2, REG_LINE_STAT, 8'h61);
		rdchk(3'h2, REG_DATA, 8'hA5);
		rdchk(3'h2, REG_DATA, 8'h3C);
		rdchk(3'h1, REG_DATA, 8'h15);
		$display("loopback test done");
	endtask
	task automatic end_of_test;
		$display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		$display("watchdog expired");
		end_of_test;
	end
	initial begin
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_reset;
		t_modem;
		t_msr;
		t_loop;
		end_of_test;
	end
endmodule
